//--- dv/dscp_ctrl_sva.sv
`timescale 1ns/10ps
module dscp_ctrl_chk (
    input wire logic                  CLK,
    input wire logic                  RST,
    input wire logic                  POWER_DOWN_N,
    input wire logic                  SELFTEST_ENABLE_PIN,
    input wire logic                  OUTPUT_ENABLE_PIN,
    input wire logic                  OUTPUT_SLEEP_STATE_SELECT,
    input wire logic                  PLL_LOCKED,
    input wire logic                  PAYLOAD_ERROR,
    input wire dscp_pkg::dscp_video_t VIDEO_IN,
    input wire dscp_pkg::dscp_cfg_t   CFG,
    input wire dscp_pkg::dscp_video_t VIDEO_OUT,
    input wire logic                  VIDEO_OE,
    input wire logic [3:0]            GPIO_OE,
    input wire logic                  LOCK,
    input wire logic                  PASS,
    input wire logic                  PLL_ENABLE,
    input wire logic                  SELFTEST_ACTIVE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    // Pins cross a two-stage synchroniser, so levels are judged after a settling run
    chk_pd_release: assert property ((!POWER_DOWN_N)[*6] |-> !VIDEO_OE && !LOCK && !PLL_ENABLE)
        else $error("outputs driven in power-down");
    chk_run_enable: assert property (POWER_DOWN_N[*6] |-> PLL_ENABLE)
        else $error("not running with power-down high");
    chk_lock_low: assert property (!PLL_LOCKED |=> !LOCK)
        else $error("lock high while unlocked");
    chk_lock_high: assert property ((POWER_DOWN_N && PLL_LOCKED)[*6] |-> LOCK)
        else $error("lock missing");
    chk_locked_drive: assert property (LOCK[*3] |-> VIDEO_OE && VIDEO_OUT.hs == $past(VIDEO_IN.hs))
        else $error("locked outputs not driven");
    chk_unlocked_oe: assert property ((!PLL_LOCKED && POWER_DOWN_N && OUTPUT_ENABLE_PIN
        && !OUTPUT_SLEEP_STATE_SELECT)[*6] |-> VIDEO_OE && !VIDEO_OUT.hs)
        else $error("unlocked outputs not driven low");
    chk_sleep_release: assert property ((!PLL_LOCKED && OUTPUT_SLEEP_STATE_SELECT)[*6] |-> !VIDEO_OE)
        else $error("unlocked outputs not released");
    chk_pass_error: assert property (SELFTEST_ACTIVE && PAYLOAD_ERROR |=> !PASS)
        else $error("pass high after error");
    chk_pass_hold: assert property (SELFTEST_ACTIVE && PASS && !PAYLOAD_ERROR |=> PASS)
        else $error("pass dropped without error");
    chk_selftest_on: assert property ((SELFTEST_ENABLE_PIN && POWER_DOWN_N)[*6] |-> SELFTEST_ACTIVE)
        else $error("self-test not active");
    chk_gpio_gate: assert property (!CFG.gpio_enable[0] |=> !GPIO_OE[0])
        else $error("gpio driven while disabled");
    cov_lock: cover property ($rose(LOCK));
    cov_fail: cover property ($fell(PASS));
    cov_pd: cover property ($fell(PLL_ENABLE));
endmodule
bind dscp_ctrl dscp_ctrl_chk i_chk (.CLK(CLK), .RST(RST), .POWER_DOWN_N(POWER_DOWN_N),
    .SELFTEST_ENABLE_PIN(SELFTEST_ENABLE_PIN), .OUTPUT_ENABLE_PIN(OUTPUT_ENABLE_PIN),
    .OUTPUT_SLEEP_STATE_SELECT(OUTPUT_SLEEP_STATE_SELECT), .PLL_LOCKED(PLL_LOCKED),
    .PAYLOAD_ERROR(PAYLOAD_ERROR), .VIDEO_IN(VIDEO_IN), .CFG(CFG), .VIDEO_OUT(VIDEO_OUT),
    .VIDEO_OE(VIDEO_OE), .GPIO_OE(GPIO_OE), .LOCK(LOCK), .PASS(PASS), .PLL_ENABLE(PLL_ENABLE),
    .SELFTEST_ACTIVE(SELFTEST_ACTIVE));

//--- dv/dscp_ctrl_tb.sv
`timescale 1ns/10ps
module dscp_ctrl_tb;
    logic                  clk, rst, pdn, st_en, st_sel, output_enable_pin, oss, m18, lck, perr, tick;
    logic [2:0]            strap;
    logic [3:0]            gin, g_out, g_oe, g_rd;
    dscp_pkg::dscp_cfg_t   cfg;
    dscp_pkg::dscp_video_t vin, vo;
    logic                  oe, lock, pass, pll_en, st_act, st_tick;
    logic [6:0]            addr;
    int                    fails, samples_checked, n;
    dscp_host i_host (.clk(clk), .rst(rst), .pix_tick(tick), .video(vin));
    dscp_ctrl i_dut (.CLK(clk), .RST(rst), .POWER_DOWN_N(pdn), .SELFTEST_ENABLE_PIN(st_en),
        .SELFTEST_CLOCK_SELECT(st_sel), .OUTPUT_ENABLE_PIN(output_enable_pin), .OUTPUT_SLEEP_STATE_SELECT(oss),
        .MODE_18BIT_STRAP(m18), .BUS_ADDRESS_STRAP(strap), .PLL_LOCKED(lck), .PAYLOAD_ERROR(perr),
        .PIXEL_CLK_TICK(tick), .VIDEO_IN(vin), .CFG(cfg), .GPIO_IN(gin), .VIDEO_OUT(vo),
        .VIDEO_OE(oe), .GPIO_OUT(g_out), .GPIO_OE(g_oe), .GPIO_READ(g_rd), .LOCK(lock), .PASS(pass),
        .PLL_ENABLE(pll_en), .SELFTEST_ACTIVE(st_act), .SELFTEST_CLK_TICK(st_tick), .BUS_ADDRESS(addr));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Ends just after an edge so synchronised levels have settled
    task automatic wait_n(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic t_power;
        @(posedge clk) pdn <= 1'b0;
        wait_n(8);
        check(oe, 1'b0);
        check({lock, pll_en}, 2'h0);
        @(posedge clk) pdn <= 1'b1;
        wait_n(8);
        check({lock, pll_en}, 2'h3);
    endtask
    task automatic t_unlock;
        @(posedge clk) lck <= 1'b0;
        wait_n(8);
        check({lock, oe}, 2'h1);
        check(vo.pix, 24'h0);
        @(posedge clk) oss <= 1'b1;
        wait_n(8);
        check(oe, 1'b0);
        @(posedge clk) {output_enable_pin, oss} <= 2'h0;
        wait_n(8);
        check(oe, 1'b0);
        @(posedge clk) {lck, output_enable_pin} <= 2'h3;
        wait_n(8);
        check(vo.pix, 24'ha5c3f3);
    endtask
    task automatic t_gpio;
        @(posedge clk) cfg <= '{mode_18bit: 1'b1, gpio_enable: 4'hf, gpio_dir_out: 4'hf, gpio_value: 4'h5,
            default: '0};
        wait_n(8);
        check({g_oe, g_out}, 8'hf5);
        check({vo.pix[9:8], vo.pix[1:0]}, 4'h0);
        @(posedge clk) cfg.gpio_dir_out <= 4'h0;
        gin <= 4'ha;
        wait_n(8);
        check(g_rd, 4'ha);
        @(posedge clk) cfg <= '{gpio_enable: 4'hf, gpio_dir_out: 4'hf, default: '0};
        wait_n(8);
        check(g_oe, 4'h0);
    endtask
    task automatic t_gpo;
        @(posedge clk) cfg <= '{mode_18bit: 1'b1, aud_db_enable: 1'b1, default: '0};
        wait_n(8);
        check(vo.pix[17], 1'b1);
        @(posedge clk) cfg <= '{gpo_enable: 5'h1f, gpo_value: 5'h0a, default: '0};
        wait_n(8);
        check({vo.aud_clk, vo.aud_wc, vo.aud_da, vo.pix[17:16]}, 5'h0a);
        @(posedge clk) cfg.gpo_value <= 5'h15;
        wait_n(8);
        check({vo.aud_clk, vo.aud_wc, vo.aud_da, vo.pix[17:16]}, 5'h15);
        @(posedge clk) cfg <= '{aud_db_enable: 1'b1, default: '0};
        wait_n(8);
        check(vo.pix[17], 1'b0);
        @(posedge clk) cfg <= '0;
    endtask
    task automatic count_ticks(input logic sel, input int exp);
        @(posedge clk) st_sel <= sel;
        wait_n(8);
        n = 0;
        repeat (100) begin
            wait_n(1);
            n += st_tick;
        end
        check(n, exp);
    endtask
    task automatic t_selftest;
        @(posedge clk) st_en <= 1'b1;
        wait_n(8);
        check({st_act, pass}, 2'h3);
        count_ticks(1'b0, 25);
        count_ticks(1'b1, 66);
        @(posedge clk) perr <= 1'b1;
        @(posedge clk) perr <= 1'b0;
        wait_n(3);
        check(pass, 1'b0);
        @(posedge clk) st_en <= 1'b0;
        wait_n(8);
        check(st_act, 1'b0);
        @(posedge clk) st_en <= 1'b1;
        wait_n(8);
        check(pass, 1'b1);
    endtask
    task automatic complete_run;
        $display("checks=%0d fails=%0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        {rst, pdn, st_en, st_sel, output_enable_pin, oss, m18, lck, perr} = 9'h192;
        {strap, gin, cfg, fails, samples_checked} = '0;
        strap = 3'h5;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        wait_n(8);
        check(addr, 7'h31);
        t_power();
        t_unlock();
        t_gpio();
        t_gpo();
        t_selftest();
        complete_run();
    end
    initial begin
        #100000;
        fails++;
        complete_run();
    end
endmodule

//--- dv/dscp_host.sv
`timescale 1ns/10ps
module dscp_host #(
    parameter logic [23:0] PIX = 24'ha5c3f3
) (
    input  wire logic             clk,
    input  wire logic             rst,
    output logic                  pix_tick,
    output dscp_pkg::dscp_video_t video
);
    logic [1:0] cnt_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= 2'h0;
        end else begin
            cnt_q <= cnt_q + 2'h1;
        end
    end
    // Pixel tick at a quarter rate; hs toggles so a stuck output shows
    assign pix_tick = (cnt_q == 2'h3);
    always_comb begin
        video = '0;
        video.pix = PIX;
        video.hs = cnt_q[0];
        video.aud_db = 1'b1;
    end
endmodule

//--- hdl/dscp_ctrl.sv
`timescale 1ns/10ps
`include "dscp_params.svh"
module dscp_ctrl #(
    parameter int                      ADDR_W     = `DSCP_ADDR_W,
    parameter int                      STRAP_W    = `DSCP_STRAP_W,
    parameter logic [`DSCP_ADDR_W-1:0] ADDR_BASE  = `DSCP_ADDR_BASE
) (
    input  wire logic                   CLK,
    input  wire logic                   RST,
    input  wire logic                   POWER_DOWN_N,
    input  wire logic                   SELFTEST_ENABLE_PIN,
    input  wire logic                   SELFTEST_CLOCK_SELECT,
    input  wire logic                   OUTPUT_ENABLE_PIN,
    input  wire logic                   OUTPUT_SLEEP_STATE_SELECT,
    input  wire logic                   MODE_18BIT_STRAP,
    input  wire logic [STRAP_W-1:0]     BUS_ADDRESS_STRAP,
    input  wire logic                   PLL_LOCKED,
    input  wire logic                   PAYLOAD_ERROR,
    input  wire logic                   PIXEL_CLK_TICK,
    input  wire dscp_pkg::dscp_video_t  VIDEO_IN,
    input  wire dscp_pkg::dscp_cfg_t    CFG,
    input  wire logic [3:0]             GPIO_IN,
    output dscp_pkg::dscp_video_t       VIDEO_OUT,
    output logic                        VIDEO_OE,
    output logic [3:0]                  GPIO_OUT,
    output logic [3:0]                  GPIO_OE,
    output logic [3:0]                  GPIO_READ,
    output logic                        LOCK,
    output logic                        PASS,
    output logic                        PLL_ENABLE,
    output logic                        SELFTEST_ACTIVE,
    output logic                        SELFTEST_CLK_TICK,
    output logic [ADDR_W-1:0]           BUS_ADDRESS
);
    dscp_pkg::dscp_state_t state_q;
    logic                  pdn_s;
    logic                  bist_en_s;
    logic                  bist_csel_s;
    logic                  oen_s;
    logic                  oss_s;
    logic                  mode_strap_s;
    logic [3:0]            gpio_s;
    logic [STRAP_W-1:0]    addr_strap_s;
    logic                  mode_18;
    logic                  bist_prev_q;
    logic [6:0]            div_acc_q;
    logic [1:0]            strap_wait_q;
    dscp_pkg::dscp_state_t state_d;
    dscp_pkg::dscp_video_t video_d;
    logic                  video_oe_d;

    function automatic logic [ADDR_W-1:0] addr_of(input logic [STRAP_W-1:0] lvl);
        addr_of = ADDR_W'(ADDR_BASE) + ADDR_W'(lvl);
    endfunction

    // One accumulator step decides both wrap and tick, so the two cannot disagree
    function automatic logic tick_due(input logic [6:0] acc);
        tick_due = (acc + 7'(`DSCP_BIST_DIV_NUM)) >= 7'(`DSCP_BIST_DIV_DEN);
    endfunction

    function automatic logic [6:0] acc_next(input logic [6:0] acc);
        if (tick_due(acc)) begin
            acc_next = acc + 7'(`DSCP_BIST_DIV_NUM) - 7'(`DSCP_BIST_DIV_DEN);
        end else begin
            acc_next = acc + 7'(`DSCP_BIST_DIV_NUM);
        end
    endfunction

    // A GPIO pin exists only in 18-bit mode, when enabled and not powered down
    function automatic logic gpio_live(input logic en, input logic mode, input dscp_pkg::dscp_state_t st);
        gpio_live = mode && en && (st != dscp_pkg::ST_POWER_DOWN);
    endfunction

    // Pins are asynchronous to CLK
    dscp_sync #(.WIDTH(6 + 4 + STRAP_W)) u_sync (
        .clk (CLK),
        .rst (RST),
        .d   ({POWER_DOWN_N, SELFTEST_ENABLE_PIN, SELFTEST_CLOCK_SELECT, OUTPUT_ENABLE_PIN,
               OUTPUT_SLEEP_STATE_SELECT, MODE_18BIT_STRAP, GPIO_IN, BUS_ADDRESS_STRAP}),
        .q   ({pdn_s, bist_en_s, bist_csel_s, oen_s, oss_s, mode_strap_s, gpio_s, addr_strap_s})
    );

    // Strap or register may select 18-bit mode
    assign mode_18 = mode_strap_s | CFG.mode_18bit;

    // Link state
    always_comb begin
        if (!pdn_s) begin
            state_d = dscp_pkg::ST_POWER_DOWN;
        end else if (PLL_LOCKED) begin
            state_d = dscp_pkg::ST_LOCKED;
        end else begin
            state_d = dscp_pkg::ST_UNLOCKED;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            state_q <= dscp_pkg::ST_POWER_DOWN;
        end else begin
            state_q <= state_d;
        end
    end

    // PLL runs whenever power-down is released
    always_ff @(posedge CLK) begin
        if (RST) begin
            PLL_ENABLE <= 1'b0;
        end else begin
            PLL_ENABLE <= pdn_s;
        end
    end

    // Lock follows the PLL one edge ahead of the outputs
    always_ff @(posedge CLK) begin
        if (RST) begin
            LOCK <= 1'b0;
        end else begin
            LOCK <= pdn_s & PLL_LOCKED;
        end
    end

    // Parallel outputs and pin muxing
    always_comb begin
        video_d    = '0;
        video_oe_d = 1'b0;
        unique case (state_q)
            dscp_pkg::ST_POWER_DOWN: begin
                video_d    = '0;
                video_oe_d = 1'b0;
            end
            dscp_pkg::ST_UNLOCKED: begin
                // Sleep value held low; select pin only chooses drive vs release
                video_d    = '0;
                video_oe_d = oen_s & ~oss_s;
            end
            dscp_pkg::ST_LOCKED: begin
                video_d    = VIDEO_IN;
                video_oe_d = 1'b1;
                if (mode_18 && CFG.aud_db_enable) begin
                    video_d.pix[`DSCP_B_LSB+1] = VIDEO_IN.aud_db;
                end
                if (CFG.gpo_enable[`DSCP_GPO_B0]) begin
                    video_d.pix[`DSCP_B_LSB] = CFG.gpo_value[`DSCP_GPO_B0];
                end
                // Applied after second audio, so the register value wins on blue 1
                if (CFG.gpo_enable[`DSCP_GPO_B1]) begin
                    video_d.pix[`DSCP_B_LSB+1] = CFG.gpo_value[`DSCP_GPO_B1];
                end
                if (CFG.gpo_enable[`DSCP_GPO_DA]) begin
                    video_d.aud_da = CFG.gpo_value[`DSCP_GPO_DA];
                end
                if (CFG.gpo_enable[`DSCP_GPO_WC]) begin
                    video_d.aud_wc = CFG.gpo_value[`DSCP_GPO_WC];
                end
                if (CFG.gpo_enable[`DSCP_GPO_CLK]) begin
                    video_d.aud_clk = CFG.gpo_value[`DSCP_GPO_CLK];
                end
                // GPIO pins take over the low red and green bits; that video is lost
                if (mode_18) begin
                    for (int i = 0; i < 2; i++) begin
                        if (CFG.gpio_enable[i]) begin
                            video_d.pix[`DSCP_R_LSB+i] = 1'b0;
                        end
                        if (CFG.gpio_enable[i+2]) begin
                            video_d.pix[`DSCP_G_LSB+i] = 1'b0;
                        end
                    end
                end
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            VIDEO_OUT <= '0;
            VIDEO_OE  <= 1'b0;
        end else begin
            VIDEO_OUT <= video_d;
            VIDEO_OE  <= video_oe_d;
        end
    end

    // GPIO pins; only present in 18-bit mode and when outputs are alive
    always_ff @(posedge CLK) begin
        if (RST) begin
            GPIO_OUT <= '0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                GPIO_OUT[i] <= gpio_live(CFG.gpio_enable[i], mode_18, state_q) & CFG.gpio_value[i];
            end
        end
    end

    // Direction comes from configuration; a pin set as input is never driven
    always_ff @(posedge CLK) begin
        if (RST) begin
            GPIO_OE <= '0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                GPIO_OE[i] <= gpio_live(CFG.gpio_enable[i], mode_18, state_q) & CFG.gpio_dir_out[i];
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            GPIO_READ <= '0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (!gpio_live(CFG.gpio_enable[i], mode_18, state_q)) begin
                    GPIO_READ[i] <= 1'b0;
                end else if (CFG.gpio_dir_out[i]) begin
                    GPIO_READ[i] <= CFG.gpio_value[i];
                end else begin
                    GPIO_READ[i] <= gpio_s[i];
                end
            end
        end
    end

    // Self-test mode and clock source
    always_ff @(posedge CLK) begin
        if (RST) begin
            SELFTEST_ACTIVE <= 1'b0;
        end else begin
            SELFTEST_ACTIVE <= bist_en_s & pdn_s;
        end
    end

    // Delayed copy marks the first active cycle of a test run
    always_ff @(posedge CLK) begin
        if (RST) begin
            bist_prev_q <= 1'b0;
        end else begin
            bist_prev_q <= SELFTEST_ACTIVE;
        end
    end

    // Fractional divider: 33 MHz on average, but tick spacing is uneven
    always_ff @(posedge CLK) begin
        if (RST) begin
            div_acc_q <= '0;
        end else begin
            div_acc_q <= acc_next(div_acc_q);
        end
    end

    // Tick held low outside self-test so no stray tick reaches the checker
    always_ff @(posedge CLK) begin
        if (RST) begin
            SELFTEST_CLK_TICK <= 1'b0;
        end else if (!bist_en_s || !pdn_s) begin
            SELFTEST_CLK_TICK <= 1'b0;
        end else if (bist_csel_s) begin
            SELFTEST_CLK_TICK <= tick_due(div_acc_q);
        end else begin
            SELFTEST_CLK_TICK <= PIXEL_CLK_TICK;
        end
    end

    // Pass flag: set at test start, any error during self-test latches it low
    always_ff @(posedge CLK) begin
        if (RST) begin
            PASS <= 1'b1;
        end else if (SELFTEST_ACTIVE && PAYLOAD_ERROR) begin
            PASS <= 1'b0;
        end else if (SELFTEST_ACTIVE && !bist_prev_q) begin
            PASS <= 1'b1;
        end else if (bist_en_s && pdn_s && !SELFTEST_ACTIVE) begin
            PASS <= 1'b1;
        end
    end

    // Strap captured once, after the synchroniser has passed the pin level through
    // A later strap change is ignored until the next reset
    always_ff @(posedge CLK) begin
        if (RST) begin
            BUS_ADDRESS  <= '0;
            strap_wait_q <= '0;
        end else if (strap_wait_q != 2'h3) begin
            strap_wait_q <= strap_wait_q + 2'h1;
            if (strap_wait_q == 2'(`DSCP_STRAP_SETTLE)) begin
                BUS_ADDRESS <= addr_of(addr_strap_s);
            end
        end
    end
endmodule

//--- hdl/dscp_params.svh
`ifndef DSCP_PARAMS_SVH
`define DSCP_PARAMS_SVH

`define DSCP_CLK_HZ            50000000
`define DSCP_BIST_CLK_HZ       33000000
`define DSCP_BIST_DIV_NUM      33
`define DSCP_BIST_DIV_DEN      50
`define DSCP_ADDR_W            7
`define DSCP_STRAP_W           3
`define DSCP_ADDR_BASE         7'h2c
`define DSCP_STRAP_SETTLE      2
`define DSCP_PIX_W             24
`define DSCP_NUM_GPIO          4
`define DSCP_NUM_GPO           5
`define DSCP_R_LSB             0
`define DSCP_G_LSB             8
`define DSCP_B_LSB             16
`define DSCP_GPO_B0            0
`define DSCP_GPO_B1            1
`define DSCP_GPO_DA            2
`define DSCP_GPO_WC            3
`define DSCP_GPO_CLK           4

`endif

//--- hdl/dscp_pkg.sv
package dscp_pkg;

    typedef enum logic [1:0] {
        ST_POWER_DOWN,
        ST_UNLOCKED,
        ST_LOCKED
    } dscp_state_t;

    typedef struct packed {
        logic [23:0] pix;
        logic        hs;
        logic        vs;
        logic        de;
        logic        pclk;
        logic        aud_clk;
        logic        aud_wc;
        logic        aud_da;
        logic        aud_db;
    } dscp_video_t;

    typedef struct packed {
        logic       mode_18bit;
        logic [3:0] gpio_enable;
        logic [3:0] gpio_dir_out;
        logic [3:0] gpio_value;
        logic [4:0] gpo_enable;
        logic [4:0] gpo_value;
        logic       aud_db_enable;
    } dscp_cfg_t;

endpackage

//--- hdl/dscp_sync.sv
`timescale 1ns/10ps
module dscp_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_q;

    // Two stages; the first is read only by the second
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule
